// File: lpmc_ctrl.sv
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
// Overview of operation
// [R01] Serial request flag held pending while its mask is 1, passed when 0.
// [R02] Converter request flag sets to 1 when a conversion completes.
// [R03] Converter request held pending while its mask is 1, enabled when 0.
// [R04] Active mode runs every function from the main oscillator.
// [R05] Standby instruction in active mode halts the processor, oscillators keep running.
// [R06] Standby keeps registers, RAM, outputs; interrupts, timers, serial, peripherals run.
// [R07] Reset during standby performs a full device reset.
// [R08] Interrupt ends standby; one instruction, then service if enable is 1.
// [R09] Stop instruction in active mode with watch select 0 enters stop.
// [R10] Stop halts all; main oscillator off; sub oscillator per stop select bit.
// [R11] Outside party holds reset at least the settling time to leave stop.
// [R12] Reset ending stop initialises and starts at program location 0.
// [R13] Wakeup falling edge in stop waits settling time, then resumes active.
// [R14] Wakeup exit from stop keeps RAM and all registers.
// [R15] Stop and watch let serial shift on external clock, without interrupts.
// [R16] In watch, external irq 0, timer A or wakeup request enters subactive.
// [R17] Stop or standby in subactive with direct transfer goes to active.
// [R18] With external main clock and wakeup exit, keep sub oscillator running.
// [R19] Stop with watch select 1, or sleep in subactive, enters watch.
// [R20] Interrupt ending watch goes active if low speed flag 0, else subactive.
// [R21] Wakeup edge ending stop leaves wakeup flag clear; elsewhere it sets it.
// [R22] Reset forces the reset state from any mode; active follows release.
module lpmc_ctrl #(
  parameter int unsigned SETTLE_CYCLES = lpmc_pkg::OSC_SETTLE_CYC,
  parameter bit SUBACTIVE_EN = 1'b1,
  parameter int unsigned WAKE_PINS = 4
) (
  input wire logic clk_i, // 50 MHz system clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic [9:0] wb_adr_i, // Byte address
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  input wire logic wb_we_i, // Write enable
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  output logic wb_ack_o, // Acknowledge
  input wire logic sby_instr_i, // Standby instruction executed
  input wire logic stop_instr_i, // Stop instruction executed
  input wire logic other_irq_i, // Unmasked request from other sources
  input wire logic timer_a_irq_i, // Timer A overflow request
  input wire logic conv_done_i, // Conversion complete pulse
  input wire logic serial_done_i, // Serial transfer end pulse
  input wire logic serial_ext_clk_i, // Serial uses external clock
  input wire logic ext_irq0_n_i, // External irq 0 pin
  input wire logic [WAKE_PINS-1:0] wakeup_n_i, // Wakeup pins
  output lpmc_pkg::lpmc_run_s run_o, // Run and clock enables
  output lpmc_pkg::lpmc_irq_s irq_o, // Unmasked requests
  output logic [2:0] mode_o, // Current mode
  output logic core_reset_o, // Core held in reset
  output logic resume_o, // Pulse: resume after sleep
  output logic cpu_irq_o, // Take interrupt now
  output logic serial_shift_o // Serial may shift
);

  // All state of the block in one register image
  typedef struct packed {
    lpmc_pkg::lpmc_mode_e mode;
    logic [lpmc_pkg::SETTLE_W-1:0] settle;
    logic [7:0] ctrl;
    logic conv_flag;
    logic conv_mask;
    logic ser_flag;
    logic ser_mask;
    logic wake_flag;
    logic wake_mask;
    logic [WAKE_PINS:0] sync1;
    logic [WAKE_PINS:0] sync2;
    logic [WAKE_PINS:0] last;
    logic ack;
    logic [31:0] rdat;
    lpmc_pkg::lpmc_run_s run;
    lpmc_pkg::lpmc_irq_s irq;
    logic core_reset;
    logic resume;
    logic cpu_irq;
    logic shift;
  } lpmc_state_s;

  // Current and next state
  lpmc_state_s st;
  lpmc_state_s next_st;

  // Mode decode used for the serial flag gate and the shift enable
  function automatic logic is_sleep_low(input lpmc_pkg::lpmc_mode_e m);
    is_sleep_low = (m == lpmc_pkg::MODE_STOP) || (m == lpmc_pkg::MODE_WATCH);
  endfunction

  // Interrupt register image: flag at bit 2, mask at bit 3
  function automatic logic [31:0] irq_word(input logic flag, input logic mask);
    irq_word = 32'h0000_0000;
    irq_word[lpmc_pkg::FLAG_BIT] = flag;
    irq_word[lpmc_pkg::MASK_BIT] = mask;
  endfunction

  // Last count of the settling wait; both oscillators run meanwhile
  localparam logic [lpmc_pkg::SETTLE_W-1:0] SETTLE_LAST =
    lpmc_pkg::SETTLE_W'(SETTLE_CYCLES - 1);

  // Decoded bus strobes and pin events
  logic [7:0] idx;
  logic wr;
  logic rd;
  logic [WAKE_PINS-1:0] wake_fall;
  logic wake_edge;
  logic irq0_fall;
  logic ser_pend;
  logic conv_pend;
  logic wake_pend;
  logic any_pend;
  logic sleep_req;

  // Bus decode and edge detection on synchronised pins
  always_comb begin
    idx = wb_adr_i[9:2];
    wr = wb_cyc_i && wb_stb_i && !st.ack && wb_we_i && wb_sel_i[0];
    rd = wb_cyc_i && wb_stb_i && !st.ack && !wb_we_i;
    wake_fall = st.last[WAKE_PINS-1:0] & ~st.sync2[WAKE_PINS-1:0];
    wake_edge = |wake_fall;
    irq0_fall = st.last[WAKE_PINS] && !st.sync2[WAKE_PINS];
    ser_pend = st.ser_flag && !st.ser_mask; // R01
    conv_pend = st.conv_flag && !st.conv_mask; // R03
    wake_pend = st.wake_flag && !st.wake_mask;
    any_pend = ser_pend || conv_pend || wake_pend || other_irq_i;
    sleep_req = sby_instr_i || stop_instr_i;
  end

  // Next-state logic for the whole block
  always_comb begin
    next_st = st;
    next_st.resume = 1'b0;
    next_st.sync1 = {!ext_irq0_n_i ? 1'b0 : 1'b1, wakeup_n_i};
    next_st.sync2 = st.sync1;
    next_st.last = st.sync2;

    // Register writes first, so hardware sets below win
    if (wr) begin
      case (idx)
        lpmc_pkg::IDX_CONV: begin
          next_st.conv_flag = wb_dat_i[lpmc_pkg::FLAG_BIT];
          next_st.conv_mask = wb_dat_i[lpmc_pkg::MASK_BIT];
        end
        lpmc_pkg::IDX_SER: begin
          next_st.ser_flag = wb_dat_i[lpmc_pkg::FLAG_BIT];
          next_st.ser_mask = wb_dat_i[lpmc_pkg::MASK_BIT];
        end
        lpmc_pkg::IDX_WAKE: begin
          next_st.wake_flag = wb_dat_i[lpmc_pkg::FLAG_BIT];
          next_st.wake_mask = wb_dat_i[lpmc_pkg::MASK_BIT];
        end
        lpmc_pkg::IDX_CTRL: begin
          next_st.ctrl = wb_dat_i[7:0];
          // Direct transfer may only be set in subactive mode
          if (st.mode != lpmc_pkg::MODE_SUBACTIVE) begin
            next_st.ctrl[lpmc_pkg::CTRL_DIRECT_TRANSFER_FLAG] = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Hardware flag sets
    if (conv_done_i) begin
      next_st.conv_flag = 1'b1; // R02
    end
    if (serial_done_i && !is_sleep_low(st.mode)) begin
      next_st.ser_flag = 1'b1; // R15
    end
    if (wake_edge && st.mode != lpmc_pkg::MODE_STOP) begin
      next_st.wake_flag = 1'b1; // R21
    end

    // Mode sequencing
    case (st.mode)
      lpmc_pkg::MODE_RESET: begin
        next_st.mode = lpmc_pkg::MODE_ACTIVE; // R22
      end
      lpmc_pkg::MODE_ACTIVE: begin
        // Direct transfer never survives active mode
        next_st.ctrl[lpmc_pkg::CTRL_DIRECT_TRANSFER_FLAG] = 1'b0;
        // Sleep is a no-op while a request waits and interrupts are off
        if (sleep_req && any_pend && !st.ctrl[lpmc_pkg::CTRL_IE]) begin
          next_st.mode = lpmc_pkg::MODE_ACTIVE;
        end else if (sby_instr_i) begin
          next_st.mode = lpmc_pkg::MODE_STANDBY; // R05
        end else if (stop_instr_i && !st.ctrl[lpmc_pkg::CTRL_WSEL]) begin
          next_st.mode = lpmc_pkg::MODE_STOP; // R09
        end else if (stop_instr_i) begin
          next_st.mode = lpmc_pkg::MODE_WATCH; // R19
        end
      end
      lpmc_pkg::MODE_STANDBY: begin
        if (any_pend) begin
          next_st.mode = lpmc_pkg::MODE_ACTIVE; // R08
          next_st.resume = 1'b1;
        end
      end
      lpmc_pkg::MODE_STOP: begin
        // Only a wakeup edge ends stop; reset is taken by the register
        if (wake_edge) begin
          next_st.mode = lpmc_pkg::MODE_SETTLE; // R13
          next_st.settle = '0;
        end
      end
      lpmc_pkg::MODE_WATCH: begin
        // External irq 0, timer A and wakeup edges end watch
        if (irq0_fall || timer_a_irq_i || wake_edge) begin
          if (SUBACTIVE_EN && st.ctrl[lpmc_pkg::CTRL_LOW_SPEED_ON_FLAG]) begin
            next_st.mode = lpmc_pkg::MODE_SUBACTIVE; // R16
            next_st.resume = 1'b1;
          end else begin
            next_st.mode = lpmc_pkg::MODE_SETTLE; // R20
            next_st.settle = '0;
          end
        end
      end
      lpmc_pkg::MODE_SUBACTIVE: begin
        if (sleep_req && st.ctrl[lpmc_pkg::CTRL_DIRECT_TRANSFER_FLAG]
            && !st.ctrl[lpmc_pkg::CTRL_LOW_SPEED_ON_FLAG]) begin
          next_st.mode = lpmc_pkg::MODE_SETTLE; // R17
          next_st.settle = '0;
        end else if (sleep_req) begin
          next_st.mode = lpmc_pkg::MODE_WATCH; // R19
        end
      end
      lpmc_pkg::MODE_SETTLE: begin
        // Count the settling time before the main clock is trusted
        if (st.settle >= SETTLE_LAST) begin
          next_st.mode = lpmc_pkg::MODE_ACTIVE; // R13
          next_st.resume = 1'b1; // R14
        end else begin
          next_st.settle = st.settle + 1'b1;
        end
      end
      default: begin
        next_st.mode = lpmc_pkg::MODE_RESET;
      end
    endcase

    // Run and clock enables per mode
    next_st.run = '0;
    next_st.core_reset = 1'b0;
    case (next_st.mode)
      lpmc_pkg::MODE_ACTIVE: begin
        next_st.run = '1; // R04
      end
      lpmc_pkg::MODE_STANDBY: begin
        next_st.run = '1; // R06
        next_st.run.cpu = 1'b0; // R05
        next_st.run.io_live = 1'b0; // R06
      end
      lpmc_pkg::MODE_STOP: begin
        next_st.run.sub_osc = !st.ctrl[lpmc_pkg::CTRL_SSTOP]; // R10
      end
      lpmc_pkg::MODE_WATCH: begin
        next_st.run.sub_osc = 1'b1;
        next_st.run.timer_a = 1'b1;
        next_st.run.lcd = 1'b1;
      end
      lpmc_pkg::MODE_SUBACTIVE: begin
        next_st.run = '1;
        next_st.run.main_osc = 1'b0;
        next_st.run.adc = 1'b0;
      end
      lpmc_pkg::MODE_SETTLE: begin
        next_st.run.main_osc = 1'b1;
        next_st.run.sub_osc = 1'b1;
      end
      default: begin
        // Reset state reached from an unused mode keeps both oscillators up; rst_i clears all run enables
        next_st.core_reset = 1'b1; // R12
        next_st.run.main_osc = 1'b1;
        next_st.run.sub_osc = 1'b1;
      end
    endcase

    // Serial shifts on external clock even in stop and watch
    next_st.shift = is_sleep_low(next_st.mode) ? serial_ext_clk_i : 1'b1; // R15

    // Requests passed onward, held pending while masked
    next_st.irq.serial = next_st.ser_flag && !next_st.ser_mask; // R01
    next_st.irq.converter = next_st.conv_flag && !next_st.conv_mask; // R03
    next_st.irq.wakeup = next_st.wake_flag && !next_st.wake_mask;
    next_st.cpu_irq = (next_st.mode == lpmc_pkg::MODE_ACTIVE) && !next_st.resume
      && st.ctrl[lpmc_pkg::CTRL_IE] && (|next_st.irq || other_irq_i); // R08

    // Bus answer: one ack per request, unmapped reads give zero
    next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
    next_st.rdat = 32'h0000_0000;
    if (rd) begin
      case (idx)
        lpmc_pkg::IDX_CONV: next_st.rdat = irq_word(st.conv_flag, st.conv_mask);
        lpmc_pkg::IDX_SER: next_st.rdat = irq_word(st.ser_flag, st.ser_mask);
        lpmc_pkg::IDX_WAKE: next_st.rdat = irq_word(st.wake_flag, st.wake_mask);
        lpmc_pkg::IDX_CTRL: next_st.rdat = {24'h00_0000, st.ctrl};
        lpmc_pkg::IDX_MODE: next_st.rdat = {29'h0000_0000, st.mode};
        default: next_st.rdat = 32'h0000_0000;
      endcase
    end
  end

  // State register; reset forces the reset state from any mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.mode <= lpmc_pkg::MODE_RESET; // R22
      st.settle <= '0;
      st.ctrl <= lpmc_pkg::CTRL_RST; // R07
      st.conv_flag <= lpmc_pkg::FLAG_RST;
      st.conv_mask <= lpmc_pkg::MASK_RST;
      st.ser_flag <= lpmc_pkg::FLAG_RST;
      st.ser_mask <= lpmc_pkg::MASK_RST;
      st.wake_flag <= lpmc_pkg::FLAG_RST;
      st.wake_mask <= lpmc_pkg::MASK_RST;
      // Pins idle high, so edge history starts high to avoid a false edge
      st.sync1 <= '1;
      st.sync2 <= '1;
      st.last <= '1;
      st.ack <= 1'b0;
      st.rdat <= 32'h0000_0000;
      st.run <= '0;
      st.irq <= '0;
      st.core_reset <= 1'b1; // R12
      st.resume <= 1'b0;
      st.cpu_irq <= 1'b0;
      st.shift <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdat;
  assign run_o = st.run;
  assign irq_o = st.irq;
  assign mode_o = st.mode;
  assign core_reset_o = st.core_reset;
  assign resume_o = st.resume;
  assign cpu_irq_o = st.cpu_irq;
  assign serial_shift_o = st.shift;

endmodule // lpmc_ctrl

// File: lpmc_ctrl_chk.sv
`timescale 1ns/10ps
// Port-level checks on mode sequencing and the register bus handshake
module lpmc_ctrl_chk (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_ack_o, // Acknowledge
  input wire logic sby_instr_i, // Standby instruction
  input wire logic other_irq_i, // Other request
  input wire logic timer_a_irq_i, // Timer A request
  input wire lpmc_pkg::lpmc_run_s run_o, // Run enables
  input wire lpmc_pkg::lpmc_irq_s irq_o, // Requests
  input wire logic [2:0] mode_o, // Mode
  input wire logic core_reset_o, // Core reset
  input wire logic resume_o, // Resume pulse
  input wire logic cpu_irq_o // Take interrupt
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus answers once, one cycle after the request
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  // Mode sequencing
  chk_reset_mode: assert property (disable iff (1'b0)
    rst_i |=> mode_o == 3'h0 && core_reset_o)
    else $error("reset did not force reset mode");
  chk_active_run: assert property (mode_o == 3'h1 |-> run_o == 9'h1FF)
    else $error("active mode with a halted function");
  chk_standby_entry: assert property (
    mode_o == 3'h1 && sby_instr_i && !other_irq_i && irq_o == 3'h0 |=> mode_o == 3'h2)
    else $error("standby instruction did not enter standby");
  chk_standby_run: assert property (mode_o == 3'h2 |->
    !run_o.cpu && run_o.main_osc && run_o.sub_osc && run_o.serial && run_o.timer_a)
    else $error("standby run enables wrong");
  chk_stop_halt: assert property (mode_o == 3'h3 |-> run_o[8:1] == 8'h00)
    else $error("stop mode left a function running");
  chk_settle_end: assert property (mode_o == 3'h6 |-> ##[1:20] mode_o == 3'h1)
    else $error("settling did not end in active");
  chk_resume_pulse: assert property (mode_o == 3'h6 ##1 mode_o == 3'h1 |-> resume_o)
    else $error("no resume pulse after settling");
  chk_watch_wake: assert property (mode_o == 3'h4 && timer_a_irq_i |->
    ##[1:4] mode_o inside {3'h5, 3'h6})
    else $error("timer request did not end watch");
  chk_irq_take: assert property (cpu_irq_o |-> mode_o == 3'h1 && !resume_o)
    else $error("interrupt taken outside active");
endmodule // lpmc_ctrl_chk

bind lpmc_ctrl lpmc_ctrl_chk u_lpmc_ctrl_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .sby_instr_i, .other_irq_i, .timer_a_irq_i, .run_o, .irq_o, .mode_o, .core_reset_o,
  .resume_o, .cpu_irq_o);

// File: lpmc_pkg.sv
package lpmc_pkg;

  // Clock and oscillator settling
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned OSC_SETTLE_US = 10_000;
  localparam int unsigned OSC_SETTLE_CYC = OSC_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SETTLE_W = 20;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONV = 8'h03;
  localparam logic [7:0] IDX_SER = 8'h23;
  localparam logic [7:0] IDX_CTRL = 8'h30;
  localparam logic [7:0] IDX_WAKE = 8'h31;
  localparam logic [7:0] IDX_MODE = 8'h32;

  // Flag and mask positions inside the interrupt registers
  localparam int unsigned FLAG_BIT = 2;
  localparam int unsigned MASK_BIT = 3;

  // Control register fields
  localparam int unsigned CTRL_LOW_SPEED_ON_FLAG = 0;
  localparam int unsigned CTRL_DIRECT_TRANSFER_FLAG = 3;
  localparam int unsigned CTRL_WSEL = 4;
  localparam int unsigned CTRL_SSTOP = 5;
  localparam int unsigned CTRL_IE = 6;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic MASK_RST = 1'b1;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_RESET,
    MODE_ACTIVE,
    MODE_STANDBY,
    MODE_STOP,
    MODE_WATCH,
    MODE_SUBACTIVE,
    MODE_SETTLE
  } lpmc_mode_e;

  // Run and clock enables handed to the rest of the chip
  typedef struct packed {
    logic cpu;
    logic timer_a;
    logic timer_bcd;
    logic serial;
    logic adc;
    logic lcd;
    logic io_live;
    logic main_osc;
    logic sub_osc;
  } lpmc_run_s;

  // Interrupt requests offered to the interrupt sequencer
  typedef struct packed {
    logic serial;
    logic converter;
    logic wakeup;
  } lpmc_irq_s;

endpackage

// File: tb_lpmc_ctrl.sv
`timescale 1ns/10ps
// Self-checking bench driving the controller through its bus and event pins
module tb_lpmc_ctrl;
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, sby_instr_i, stop_instr_i;
  logic other_irq_i, timer_a_irq_i, conv_done_i, serial_done_i, serial_ext_clk_i;
  logic ext_irq0_n_i, core_reset_o, resume_o, cpu_irq_o, serial_shift_o;
  logic [9:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0] wb_sel_i, wakeup_n_i;
  logic [2:0] mode_o;
  lpmc_pkg::lpmc_run_s run_o;
  lpmc_pkg::lpmc_irq_s irq_o;
  int fail_count, compares;
  localparam int unsigned SETTLE = 8;

  lpmc_ctrl #(.SETTLE_CYCLES(SETTLE), .SUBACTIVE_EN(1'b1), .WAKE_PINS(4)) u_lpmc_ctrl (.clk_i,
    .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .sby_instr_i, .stop_instr_i, .other_irq_i, .timer_a_irq_i, .conv_done_i,
    .serial_done_i, .serial_ext_clk_i, .ext_irq0_n_i, .wakeup_n_i, .run_o, .irq_o, .mode_o,
    .core_reset_o, .resume_o, .cpu_irq_o, .serial_shift_o);

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Verdict and end of run
  task finish_test;
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
    end
  endtask

  // One classic bus cycle, held until ack is sampled
  task wb(input logic we, input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= d;
    for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
    if (n == 50) check(32'h0, 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task rdchk(input logic [7:0] idx, input logic [31:0] e);
    wb(1'b0, idx, 32'h0);
    check(rd, e);
  endtask

  task wait_mode(input logic [2:0] m);
    for (int n = 0; n < 40 && mode_o !== m; n++) @(posedge clk_i);
    check({29'h0, mode_o}, {29'h0, m});
  endtask

  // Sleep instruction pulse: 1 for stop, 0 for standby
  task instr(input logic stop);
    @(posedge clk_i);
    if (stop) stop_instr_i <= 1'b1;
    else sby_instr_i <= 1'b1;
    @(posedge clk_i);
    stop_instr_i <= 1'b0;
    sby_instr_i <= 1'b0;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    finish_test;
  end

  // Main sequence
  initial begin
    {rst_i, wb_we_i, wb_cyc_i, wb_stb_i, sby_instr_i, stop_instr_i} = 6'h20;
    {other_irq_i, timer_a_irq_i, conv_done_i, serial_done_i} = 4'h0;
    {serial_ext_clk_i, ext_irq0_n_i, wb_sel_i, wakeup_n_i} = 10'h3FF;
    wb_adr_i = 10'h000;
    wb_dat_i = 32'h0;
    fail_count = 0;
    compares = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_mode(3'h1);
    rdchk(8'h10, 32'h0);
    rdchk(lpmc_pkg::IDX_CTRL, 32'h0);
    // Flag held by mask, passed once the mask clears
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      if (i == 1) serial_done_i <= 1'b1;
      else conv_done_i <= 1'b1;
      @(posedge clk_i);
      {serial_done_i, conv_done_i} <= 2'b00;
      rdchk(i ? lpmc_pkg::IDX_SER : lpmc_pkg::IDX_CONV, 32'h0C);
      check({31'h0, irq_o[1+i]}, 32'h0);
      wb(1'b1, i ? lpmc_pkg::IDX_SER : lpmc_pkg::IDX_CONV, 32'h04);
      repeat (2) @(posedge clk_i);
      check({31'h0, irq_o[1+i]}, 32'h1);
      wb(1'b1, i ? lpmc_pkg::IDX_SER : lpmc_pkg::IDX_CONV, 32'h00);
    end
    // Sleep refused while an unmasked request waits and interrupts are off
    conv_done_i <= 1'b1;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
    instr(1'b0);
    repeat (2) @(posedge clk_i);
    check({29'h0, mode_o}, 32'h1);
    wb(1'b1, lpmc_pkg::IDX_CONV, 32'h00);
    // Standby ended by a request, then serviced with enable set
    wb(1'b1, lpmc_pkg::IDX_CTRL, 32'h40);
    instr(1'b0);
    wait_mode(3'h2);
    other_irq_i <= 1'b1;
    wait_mode(3'h1);
    for (int n = 0; n < 20 && cpu_irq_o !== 1'b1; n++) @(posedge clk_i);
    check({31'h0, cpu_irq_o}, 32'h1);
    other_irq_i <= 1'b0;
    // Stop with sub oscillator on and off, woken by pin 0 and pin 3
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, lpmc_pkg::IDX_CTRL, k ? 32'h20 : 32'h00);
      instr(1'b1);
      wait_mode(3'h3);
      check({23'h0, run_o}, k ? 32'h0 : 32'h1);
      serial_done_i <= 1'b1;
      serial_ext_clk_i <= k ? 1'b0 : 1'b1;
      @(posedge clk_i);
      serial_done_i <= 1'b0;
      @(posedge clk_i);
      check({31'h0, serial_shift_o}, k ? 32'h0 : 32'h1);
      wakeup_n_i <= k ? 4'h7 : 4'hE;
      wait_mode(3'h1);
      wakeup_n_i <= 4'hF;
      serial_ext_clk_i <= 1'b1;
      rdchk(lpmc_pkg::IDX_WAKE, 32'h08);
      rdchk(lpmc_pkg::IDX_SER, 32'h00);
    end
    // Watch, subactive and the ways back to active
    wb(1'b1, lpmc_pkg::IDX_CTRL, 32'h11);
    instr(1'b1);
    wait_mode(3'h4);
    @(posedge clk_i);
    timer_a_irq_i <= 1'b1;
    @(posedge clk_i);
    timer_a_irq_i <= 1'b0;
    wait_mode(3'h5);
    instr(1'b0);
    wait_mode(3'h4);
    wb(1'b1, lpmc_pkg::IDX_CTRL, 32'h10);
    ext_irq0_n_i <= 1'b0;
    wait_mode(3'h1);
    ext_irq0_n_i <= 1'b1;
    wb(1'b1, lpmc_pkg::IDX_CTRL, 32'h11);
    instr(1'b1);
    wait_mode(3'h4);
    wakeup_n_i <= 4'hE;
    wait_mode(3'h5);
    wakeup_n_i <= 4'hF;
    wb(1'b1, lpmc_pkg::IDX_CTRL, 32'h18);
    instr(1'b0);
    wait_mode(3'h1);
    rdchk(lpmc_pkg::IDX_CTRL, 32'h10);
    rdchk(lpmc_pkg::IDX_WAKE, 32'h0C);
    // Reset out of standby
    wb(1'b1, lpmc_pkg::IDX_WAKE, 32'h08);
    instr(1'b0);
    wait_mode(3'h2);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check({31'h0, core_reset_o}, 32'h1);
    rst_i <= 1'b0;
    wait_mode(3'h1);
    rdchk(lpmc_pkg::IDX_CTRL, 32'h00);
    rdchk(lpmc_pkg::IDX_SER, 32'h08);
    // Reset out of stop, held for the settling time
    instr(1'b1);
    wait_mode(3'h3);
    rst_i <= 1'b1;
    repeat (SETTLE + 1) @(posedge clk_i);
    check({31'h0, core_reset_o}, 32'h1);
    check({23'h0, run_o}, 32'h0);
    rst_i <= 1'b0;
    wait_mode(3'h1);
    rdchk(lpmc_pkg::IDX_MODE, 32'h01);
    finish_test;
  end
endmodule // tb_lpmc_ctrl
